// ===== design/phy_negotiation_strap_led_control.sv
// Negotiation control, crossover, strap latching, isolate and LED control.
// Functional notes
// RULE1: restart bit write restarts negotiation anytime.
// RULE2: lost link after negotiation resumes negotiation.
// RULE3: renegotiation silences transmit until break-link expiry.
// RULE4: software clears then sets enable after forced start.
// RULE5: negotiation allowed about three seconds before timeout.
// RULE6: automatic crossover picks pairs with random seed.
// RULE7: crossover on after reset, strap or register configurable.
// RULE8: force-crossover bit always swaps the pairs.
// RULE9: five address straps latched into control bits.
// RULE10: strapped address zero isolates, written zero does not.
// RULE11: unstrapped address defaults to one.
// RULE12: system gives each device a unique address.
// RULE13: isolate bit in basic control enters isolate.
// RULE14: isolate ignores transmit, floats MII, keeps management.
// RULE15: isolate keeps idles, pulses and negotiation running.
// RULE16: LED scheme from control bits or strap.
// RULE17: link LED steady, or blinking with activity.
// RULE18: ten megabit link after seven pulses or packet.
// RULE19: rate LED high in 100, low in 10.
// RULE20: third LED shows activity, collision or duplex.
// RULE21: LED polarity inverse of its sampled strap.
// RULE22: override register drives LEDs, reads register only.
// RULE23: negotiation straps force mode or set advertisement.
// RULE24: activity events stretched to visible length.
`timescale 1ns/1ps
`include "phy_cfg.svh"
module phy_negotiation_strap_led_control #(
	parameter int BREAK_CYCLES = `BREAK_LINK_MS * `CLK_KHZ,
	parameter int DONE_CYCLES = `AN_DONE_MS * `CLK_KHZ,
	parameter int LOSS_CYCLES = `LINK_LOSS_MS * `CLK_KHZ,
	parameter int SLOT_CYCLES = `XOVER_SLOT_MS * `CLK_KHZ,
	parameter int STRETCH_CYCLES = `STRETCH_MS * `CLK_KHZ,
	parameter int BLINK_CYCLES = `BLINK_MS * `CLK_KHZ
) (
	// Clock, reset and clock enable
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// Strap pins
	input wire logic [4:0] management_address_strap_i,
	input wire logic negotiation_enable_strap_i,
	input wire logic negotiation_mode_strap_high_i,
	input wire logic negotiation_mode_strap_low_i,
	input wire logic led_scheme_select_strap_i,
	input wire logic automatic_crossover_strap_i,
	// Management register port
	input wire logic [4:0] mgmt_addr_i,
	input wire logic [15:0] mgmt_wdata_i,
	input wire logic mgmt_wr_i,
	input wire logic mgmt_rd_i,
	output logic [15:0] mgmt_rdata_o,
	output logic mgmt_rvalid_o,
	// Receive and transmit side status
	input wire logic signal_detect_i,
	input wire logic link_pulse_i,
	input wire logic valid_packet_i,
	input wire logic an_complete_i,
	input wire logic speed100_i,
	input wire logic full_duplex_i,
	input wire logic tx_activity_i,
	input wire logic rx_activity_i,
	input wire logic collision_i,
	// Negotiation and media control
	output logic an_enable_o,
	output logic tx_quiet_o,
	output logic flp_enable_o,
	output logic an_timeout_o,
	output logic forced_speed100_o,
	output logic forced_full_duplex_o,
	output logic [3:0] advertise_o,
	output logic mdi_swap_o,
	output logic link_good_o,
	// MII isolate control
	output logic isolate_o,
	output logic mii_oe_o,
	output logic tx_accept_o,
	output logic media_data_en_o,
	output logic media_idle_en_o,
	output logic [4:0] phy_address_o,
	// LED pins
	output logic link_indicator_o,
	output logic rate_indicator_o,
	output logic activity_collision_indicator_o
);
	////////////////////////////////////////////////////////////////////////////////
	// Strap synchroniser and latch.
	logic [9:0] strap_raw, strap_s1_r, strap_s2_r;
	logic [1:0] settle_r, settle_nxt;
	logic done_r, done_nxt, latch;
	logic [2:0] led_low_r, led_low_nxt;

	assign strap_raw = {automatic_crossover_strap_i, led_scheme_select_strap_i,
		negotiation_enable_strap_i, negotiation_mode_strap_high_i,
		negotiation_mode_strap_low_i, management_address_strap_i};

	always_comb begin
		settle_nxt = (settle_r != `STRAP_SETTLE) ? settle_r + 2'h1 : settle_r;
		latch = (settle_r == `STRAP_SETTLE) && !done_r; // see RULE9
		done_nxt = done_r || latch;
		led_low_nxt = latch ? {strap_s2_r[7], strap_s2_r[6], strap_s2_r[5]} : led_low_r; // see RULE21
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			strap_s1_r <= 10'h0;
			strap_s2_r <= 10'h0;
			settle_r <= 2'h0;
			done_r <= 1'b0;
			led_low_r <= 3'h0;
		end else if (ce_i) begin
			strap_s1_r <= strap_raw;
			strap_s2_r <= strap_s1_r;
			settle_r <= settle_nxt;
			done_r <= done_nxt;
			led_low_r <= led_low_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Management registers.
	logic [15:0] bc_r, bc_nxt;
	logic [3:0] adv_r, adv_nxt;
	logic [5:0] ledo_r, ledo_nxt;
	logic [1:0] xo_r, xo_nxt;
	logic [1:0] cfg_r, cfg_nxt;
	logic [4:0] addr_r, addr_nxt;
	logic iso_strap_r, iso_strap_nxt, arm_r, arm_nxt, restart_r, restart_nxt;
	logic [15:0] rdata_nxt;
	logic wr_bc;

	always_comb begin
		bc_nxt = bc_r;
		adv_nxt = adv_r;
		ledo_nxt = ledo_r;
		xo_nxt = xo_r;
		cfg_nxt = cfg_r;
		addr_nxt = addr_r;
		iso_strap_nxt = iso_strap_r;
		arm_nxt = arm_r;
		wr_bc = mgmt_wr_i && (mgmt_addr_i == `REG_BASIC);
		restart_nxt = wr_bc && mgmt_wdata_i[`BC_RESTART]; // see RULE1
		if (latch) begin
			addr_nxt = strap_s2_r[4:0]; // see RULE9
			iso_strap_nxt = (strap_s2_r[4:0] == 5'h00); // see RULE10
			cfg_nxt = {1'b0, strap_s2_r[8]}; // see RULE16
			xo_nxt = {strap_s2_r[9], 1'b0}; // see RULE7
			bc_nxt[`BC_ANEN] = strap_s2_r[7];
			arm_nxt = strap_s2_r[7];
			if (strap_s2_r[7]) begin
				case (strap_s2_r[6:5]) // see RULE23
					2'h0: adv_nxt = 4'h3;
					2'h1: adv_nxt = 4'hC;
					2'h2: adv_nxt = 4'h5;
					default: adv_nxt = 4'hF;
				endcase
			end else begin
				bc_nxt[`BC_SPEED] = strap_s2_r[6]; // see RULE23
				bc_nxt[`BC_DUPLEX] = strap_s2_r[5];
			end
		end else if (mgmt_wr_i) begin
			case (mgmt_addr_i)
				`REG_BASIC: begin
					bc_nxt = mgmt_wdata_i & `BC_WMASK; // see RULE13
					if (!mgmt_wdata_i[`BC_ANEN])
						arm_nxt = 1'b1; // see RULE4
				end
				`REG_ADV: adv_nxt = mgmt_wdata_i[8:5];
				`REG_LEDOVR: ledo_nxt = mgmt_wdata_i[5:0]; // see RULE22
				`REG_PHYCTL: begin
					xo_nxt = mgmt_wdata_i[`PC_AUTOX:`PC_FORCEX]; // see RULE7
					cfg_nxt = mgmt_wdata_i[`PC_LEDCFG_HI:`PC_LEDCFG_LO]; // see RULE16
					addr_nxt = mgmt_wdata_i[4:0]; // see RULE10
				end
				default: ;
			endcase
		end
		case (mgmt_addr_i)
			`REG_BASIC: rdata_nxt = bc_r;
			`REG_ADV: rdata_nxt = {7'h0, adv_r, `ADV_SELECTOR};
			`REG_LEDOVR: rdata_nxt = {10'h0, ledo_r}; // see RULE22
			`REG_PHYCTL: rdata_nxt = {xo_r, 7'h0, cfg_r, addr_r};
			default: rdata_nxt = 16'h0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bc_r <= 16'h0;
			adv_r <= `ADV_RESET;
			ledo_r <= 6'h0;
			xo_r <= 2'h2;
			cfg_r <= 2'h0;
			addr_r <= `ADDR_RESET; // see RULE11
			iso_strap_r <= 1'b0;
			arm_r <= 1'b0;
			restart_r <= 1'b0;
			mgmt_rdata_o <= 16'h0;
			mgmt_rvalid_o <= 1'b0;
		end else if (ce_i) begin
			bc_r <= bc_nxt;
			adv_r <= adv_nxt;
			ledo_r <= ledo_nxt;
			xo_r <= xo_nxt;
			cfg_r <= cfg_nxt;
			addr_r <= addr_nxt;
			iso_strap_r <= iso_strap_nxt;
			arm_r <= arm_nxt;
			restart_r <= restart_nxt;
			if (mgmt_rd_i)
				mgmt_rdata_o <= rdata_nxt; // see RULE14
			mgmt_rvalid_o <= mgmt_rd_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Ten megabit link detection.
	logic [2:0] nlp_r, nlp_nxt;
	logic [31:0] loss_r, loss_nxt;
	logic link10_r, link10_nxt, link_good;

	always_comb begin
		nlp_nxt = nlp_r;
		link10_nxt = link10_r;
		loss_nxt = loss_r + 32'h1;
		if (link_pulse_i || valid_packet_i) begin
			loss_nxt = 32'h0;
			if (nlp_r != `NLP_NEEDED)
				nlp_nxt = nlp_r + 3'h1;
			if (valid_packet_i || nlp_r == `NLP_NEEDED - 3'h1 || nlp_r == `NLP_NEEDED)
				link10_nxt = 1'b1; // see RULE18
		end else if (loss_r >= 32'(LOSS_CYCLES - 1)) begin
			loss_nxt = loss_r;
			nlp_nxt = 3'h0;
			link10_nxt = 1'b0; // see RULE18
		end
		link_good = speed100_i ? signal_detect_i : link10_r;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nlp_r <= 3'h0;
			loss_r <= 32'h0;
			link10_r <= 1'b0;
		end else if (ce_i) begin
			nlp_r <= nlp_nxt;
			loss_r <= loss_nxt;
			link10_r <= link10_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Negotiation sequencing.
	logic an_active, seq_quiet, seq_flp, seq_tmo;

	assign an_active = bc_r[`BC_ANEN] && arm_r; // see RULE4

	an_sequencer #(
		.BREAK_CYCLES(BREAK_CYCLES),
		.DONE_CYCLES(DONE_CYCLES)
	) u_seq (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.an_active_i(an_active),
		.restart_i(restart_r),
		.link_good_i(link_good),
		.an_complete_i(an_complete_i),
		.quiet_o(seq_quiet),
		.flp_o(seq_flp),
		.timeout_o(seq_tmo)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Crossover selection.
	logic [15:0] lfsr_r, lfsr_nxt;
	logic [31:0] slot_r, slot_nxt;
	logic mdix_r, mdix_nxt, auto_ok;

	always_comb begin
		lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		auto_ok = xo_r[1] && an_active; // see RULE7
		slot_nxt = (slot_r >= 32'(SLOT_CYCLES - 1)) ? 32'h0 : slot_r + 32'h1;
		mdix_nxt = mdix_r;
		if (!auto_ok)
			mdix_nxt = 1'b0;
		else if (!link_good && slot_r >= 32'(SLOT_CYCLES - 1) && lfsr_r[0])
			mdix_nxt = !mdix_r; // see RULE6
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lfsr_r <= 16'hACE1;
			slot_r <= 32'h0;
			mdix_r <= 1'b0;
		end else if (ce_i) begin
			lfsr_r <= lfsr_nxt;
			slot_r <= slot_nxt;
			mdix_r <= mdix_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registered outputs.
	logic isolate;

	assign isolate = iso_strap_r || bc_r[`BC_ISOLATE]; // see RULE10

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			an_enable_o <= 1'b0;
			tx_quiet_o <= 1'b0;
			flp_enable_o <= 1'b0;
			an_timeout_o <= 1'b0;
			forced_speed100_o <= 1'b0;
			forced_full_duplex_o <= 1'b0;
			advertise_o <= `ADV_RESET;
			mdi_swap_o <= 1'b0;
			link_good_o <= 1'b0;
			isolate_o <= 1'b0;
			mii_oe_o <= 1'b0;
			tx_accept_o <= 1'b0;
			media_data_en_o <= 1'b0;
			media_idle_en_o <= 1'b0;
			phy_address_o <= `ADDR_RESET;
		end else if (ce_i) begin
			an_enable_o <= an_active;
			tx_quiet_o <= seq_quiet; // see RULE3
			flp_enable_o <= seq_flp;
			an_timeout_o <= seq_tmo;
			forced_speed100_o <= bc_r[`BC_SPEED];
			forced_full_duplex_o <= bc_r[`BC_DUPLEX];
			advertise_o <= adv_r;
			mdi_swap_o <= xo_r[0] || mdix_r; // see RULE8
			link_good_o <= link_good;
			isolate_o <= isolate; // see RULE13
			mii_oe_o <= !isolate; // see RULE14
			tx_accept_o <= !isolate && !seq_quiet; // see RULE14
			media_data_en_o <= !isolate && !seq_quiet; // see RULE15
			media_idle_en_o <= !seq_quiet; // see RULE15
			phy_address_o <= addr_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// LED driver.
	led_status_if lst ();

	assign lst.link_good = link_good;
	assign lst.speed100 = speed100_i;
	assign lst.full_duplex = full_duplex_i;
	assign lst.activity = tx_activity_i || rx_activity_i;
	assign lst.collision = collision_i && !full_duplex_i; // see RULE20

	logic [2:0] leds;

	led_driver #(
		.STRETCH_CYCLES(STRETCH_CYCLES),
		.BLINK_CYCLES(BLINK_CYCLES)
	) u_led (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.st(lst.sink),
		.cfg_i(cfg_r),
		.act_low_i(led_low_r),
		.ovr_en_i(ledo_r[5:3]),
		.ovr_val_i(ledo_r[2:0]),
		.leds_o(leds)
	);

	assign link_indicator_o = leds[0];
	assign rate_indicator_o = leds[1];
	assign activity_collision_indicator_o = leds[2];

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	AST_ISO_STRAP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && iso_strap_r |=> isolate_o && !mii_oe_o && !tx_accept_o) // see RULE10
		else $error("strapped address zero did not isolate");
	AST_ADDR_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && !latch && mgmt_wr_i && mgmt_addr_i == `REG_PHYCTL && !iso_strap_r
		&& !bc_r[`BC_ISOLATE] |=> ##1 !isolate_o) // see RULE10
		else $error("written address zero entered isolate");
	AST_FORCE_SWAP: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && xo_r[0] |=> mdi_swap_o) // see RULE8
		else $error("force crossover did not swap pairs");
	AST_NO_AUTO_FORCED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && !an_active && !xo_r[0] && !mdix_r |=> !mdi_swap_o && !mdix_r) // see RULE7
		else $error("crossover switched in forced mode");
	AST_LINK_SEVEN: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && link_pulse_i && nlp_r == 3'h6 |=> link10_r) // see RULE18
		else $error("link not declared after seventh pulse");
	AST_ISO_IDLES: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		isolate_o && !tx_quiet_o |-> media_idle_en_o && !media_data_en_o) // see RULE15
		else $error("isolate stopped idles or passed data");
endmodule : phy_negotiation_strap_led_control

// ===== include/phy_cfg.svh
// Register offsets, field positions, reset values and timing constants.
`ifndef PHY_CFG_SVH
`define PHY_CFG_SVH
`define REG_BASIC 5'h00
`define REG_ADV 5'h04
`define REG_LEDOVR 5'h18
`define REG_PHYCTL 5'h19
`define BC_LOOPBACK 14
`define BC_SPEED 13
`define BC_ANEN 12
`define BC_PWRDN 11
`define BC_ISOLATE 10
`define BC_RESTART 9
`define BC_DUPLEX 8
`define BC_COLTEST 7
`define BC_WMASK 16'h7D80
`define PC_AUTOX 15
`define PC_FORCEX 14
`define PC_LEDCFG_HI 6
`define PC_LEDCFG_LO 5
`define ADV_SELECTOR 5'h01
`define ADV_RESET 4'hF
`define ADDR_RESET 5'h01
`define NLP_NEEDED 3'h7
`define CLK_KHZ 125000
`define BREAK_LINK_MS 1500
`define AN_DONE_MS 3000
`define LINK_LOSS_MS 50
`define XOVER_SLOT_MS 62
`define STRETCH_MS 50
`define BLINK_MS 100
`define STRAP_SETTLE 2'h3
`endif

// ===== include/phy_pkg.sv
// Types shared by the negotiation and LED logic.
package phy_pkg;
	typedef enum logic [1:0] {
		AN_OFF = 2'b00,
		AN_BREAK = 2'b01,
		AN_NEG = 2'b10,
		AN_UP = 2'b11
	} an_state_t;
	typedef enum logic [1:0] {
		SCH_1 = 2'b01,
		SCH_2 = 2'b10,
		SCH_3 = 2'b11
	} led_scheme_t;
endpackage : phy_pkg

// ===== include/led_status_if.sv
// Link status carried from the top level to the LED driver.
`timescale 1ns/1ps
interface led_status_if;
	logic link_good;
	logic speed100;
	logic full_duplex;
	logic activity;
	logic collision;
	modport src (output link_good, speed100, full_duplex, activity, collision);
	modport sink (input link_good, speed100, full_duplex, activity, collision);
endinterface : led_status_if

// ===== design/an_sequencer.sv
// Negotiation restart, break-link hold-off and completion timeout.
`timescale 1ns/1ps
`include "phy_cfg.svh"
module an_sequencer #(
	parameter int BREAK_CYCLES = `BREAK_LINK_MS * `CLK_KHZ,
	parameter int DONE_CYCLES = `AN_DONE_MS * `CLK_KHZ
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// Control
	input wire logic an_active_i,
	input wire logic restart_i,
	input wire logic link_good_i,
	input wire logic an_complete_i,
	// Status
	output logic quiet_o,
	output logic flp_o,
	output logic timeout_o
);
	phy_pkg::an_state_t st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic tmo_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		tmo_nxt = timeout_o;
		case (st_r)
			phy_pkg::AN_OFF: begin
				if (an_active_i) begin
					st_nxt = phy_pkg::AN_BREAK;
					cnt_nxt = 32'h0;
				end
			end
			phy_pkg::AN_BREAK: begin
				cnt_nxt = cnt_r + 32'h1;
				if (cnt_r >= 32'(BREAK_CYCLES - 1)) begin // see RULE3
					st_nxt = phy_pkg::AN_NEG;
					cnt_nxt = 32'h0;
				end
			end
			phy_pkg::AN_NEG: begin
				if (cnt_r < 32'(DONE_CYCLES - 1))
					cnt_nxt = cnt_r + 32'h1;
				else
					tmo_nxt = 1'b1; // see RULE5
				if (an_complete_i && link_good_i) begin
					st_nxt = phy_pkg::AN_UP;
					tmo_nxt = 1'b0;
				end
			end
			phy_pkg::AN_UP: begin
				if (!link_good_i) begin // see RULE2
					st_nxt = phy_pkg::AN_NEG;
					cnt_nxt = 32'h0;
				end
			end
			default: st_nxt = phy_pkg::AN_OFF;
		endcase
		if (an_active_i && restart_i) begin // see RULE1
			st_nxt = phy_pkg::AN_BREAK;
			cnt_nxt = 32'h0;
			tmo_nxt = 1'b0;
		end
		if (!an_active_i) begin
			st_nxt = phy_pkg::AN_OFF;
			tmo_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= phy_pkg::AN_OFF;
			cnt_r <= 32'h0;
			timeout_o <= 1'b0;
			quiet_o <= 1'b0;
			flp_o <= 1'b0;
		end else if (ce_i) begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			timeout_o <= tmo_nxt;
			quiet_o <= (st_nxt == phy_pkg::AN_BREAK);
			flp_o <= (st_nxt == phy_pkg::AN_NEG);
		end
	end

	AST_QUIET_AFTER_RESTART: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && an_active_i && restart_i |=> quiet_o && !flp_o) // see RULE3
		else $error("break-link hold-off did not start on restart");
	AST_FLP_AFTER_BREAK: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$fell(quiet_o) && $past(an_active_i) && $past(ce_i) && !$past(restart_i)
		|-> flp_o) // see RULE3
		else $error("no FLP bursts after break-link timer");
endmodule : an_sequencer

// ===== design/led_driver.sv
// Three status LEDs: schemes, activity stretching, polarity and override.
`timescale 1ns/1ps
`include "phy_cfg.svh"
module led_driver #(
	parameter int STRETCH_CYCLES = `STRETCH_MS * `CLK_KHZ,
	parameter int BLINK_CYCLES = `BLINK_MS * `CLK_KHZ
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// Status and configuration
	led_status_if.sink st,
	input wire logic [1:0] cfg_i,
	input wire logic [2:0] act_low_i,
	input wire logic [2:0] ovr_en_i,
	input wire logic [2:0] ovr_val_i,
	// LED pins, bit 0 link, bit 1 rate, bit 2 activity, collision or duplex
	output logic [2:0] leds_o
);
	logic [31:0] act_cnt_r, act_cnt_nxt, blk_cnt_r, blk_cnt_nxt;
	logic phase_r, phase_nxt, act_on;
	logic [2:0] on, leds_nxt;
	phy_pkg::led_scheme_t sch;

	always_comb begin
		sch = cfg_i[0] ? phy_pkg::SCH_1 : (cfg_i[1] ? phy_pkg::SCH_3 : phy_pkg::SCH_2); // see RULE16
		act_cnt_nxt = st.activity ? 32'(STRETCH_CYCLES - 1) :
			(act_cnt_r != 32'h0 ? act_cnt_r - 32'h1 : 32'h0); // see RULE24
		act_on = st.activity || (act_cnt_r != 32'h0);
		blk_cnt_nxt = blk_cnt_r + 32'h1;
		phase_nxt = phase_r;
		if (blk_cnt_r >= 32'(BLINK_CYCLES - 1)) begin
			blk_cnt_nxt = 32'h0;
			phase_nxt = !phase_r;
		end
		on[1] = st.speed100; // see RULE19
		case (sch)
			phy_pkg::SCH_1: begin
				on[0] = st.link_good; // see RULE17
				on[2] = act_on; // see RULE20
			end
			phy_pkg::SCH_2: begin
				on[0] = st.link_good && !(act_on && phase_r); // see RULE17
				on[2] = st.collision; // see RULE20
			end
			phy_pkg::SCH_3: begin
				on[0] = st.link_good && !(act_on && phase_r);
				on[2] = st.full_duplex; // see RULE20
			end
			default: begin
				on[0] = 1'b0;
				on[2] = 1'b0;
			end
		endcase
		for (int i = 0; i < 3; i++)
			leds_nxt[i] = (ovr_en_i[i] ? ovr_val_i[i] : on[i]) ^ act_low_i[i]; // see RULE21
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			act_cnt_r <= 32'h0;
			blk_cnt_r <= 32'h0;
			phase_r <= 1'b0;
			leds_o <= 3'h0;
		end else if (ce_i) begin
			act_cnt_r <= act_cnt_nxt;
			blk_cnt_r <= blk_cnt_nxt;
			phase_r <= phase_nxt;
			leds_o <= leds_nxt;
		end
	end

	AST_RATE_LED: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && !ovr_en_i[1] |=> leds_o[1] == ($past(st.speed100) ^ $past(act_low_i[1]))) // see RULE19
		else $error("rate indicator does not follow speed");
	AST_OVERRIDE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		ce_i && ovr_en_i[2] |=> leds_o[2] == ($past(ovr_val_i[2]) ^ $past(act_low_i[2]))) // see RULE22
		else $error("LED override not applied");
endmodule : led_driver

// ===== bench/link_partner_model.sv
// Far side model: address strap wiring and a partner sending link pulses.
`timescale 1ns/1ps
module link_partner_model #(
	parameter logic [4:0] ADDR = 5'h05
) (
	// Clock and selection
	input wire logic clk_i,
	input wire logic sel_zero_i,
	// Strap and pulse outputs
	output logic [4:0] addr_strap_o,
	output logic link_pulse_o
);
	// Each device on the shared management line has its own address.
	assign addr_strap_o = sel_zero_i ? 5'h00 : ADDR;
	initial link_pulse_o = 1'b0;
	// Sends one-cycle pulses with idle cycles between them.
	task automatic pulses(input int cnt);
		for (int i = 0; i < cnt; i++) begin
			@(negedge clk_i) link_pulse_o = 1'b1;
			@(negedge clk_i) link_pulse_o = 1'b0;
			repeat (2) @(negedge clk_i);
		end
	endtask : pulses
endmodule : link_partner_model

// ===== bench/tb.sv
// Testbench: straps, isolate, negotiation, crossover and LED scenarios.
`timescale 1ns/1ps
`include "phy_cfg.svh"
module tb;
	logic clk_i, rst_b_i, ce_i, zero_addr, mgmt_wr_i, mgmt_rd_i, mgmt_rvalid_o;
	logic [4:0] management_address_strap_i, mgmt_addr_i, phy_address_o;
	logic negotiation_enable_strap_i, negotiation_mode_strap_high_i;
	logic negotiation_mode_strap_low_i, led_scheme_select_strap_i, automatic_crossover_strap_i;
	logic [15:0] mgmt_wdata_i, mgmt_rdata_o, rd;
	logic signal_detect_i, link_pulse_i, valid_packet_i, an_complete_i, speed100_i;
	logic full_duplex_i, tx_activity_i, rx_activity_i, collision_i, tx_quiet_o;
	logic flp_enable_o, an_timeout_o, mdi_swap_o, link_good_o, isolate_o, mii_oe_o;
	logic tx_accept_o, media_data_en_o, media_idle_en_o;
	logic [3:0] advertise_o;
	logic an_enable_o, forced_speed100_o, forced_full_duplex_o;
	logic link_indicator_o, rate_indicator_o, activity_collision_indicator_o;
	int bad_count = 0;
	int checks = 0;
	int n;
	////////////////////////////////////////////////////////////////////////////////
	phy_negotiation_strap_led_control #(.BREAK_CYCLES(20), .DONE_CYCLES(40),
		.LOSS_CYCLES(30), .SLOT_CYCLES(8), .STRETCH_CYCLES(5), .BLINK_CYCLES(4)) DUT (
		.clk_i, .rst_b_i, .ce_i, .management_address_strap_i, .negotiation_enable_strap_i,
		.negotiation_mode_strap_high_i, .negotiation_mode_strap_low_i,
		.led_scheme_select_strap_i, .automatic_crossover_strap_i, .mgmt_addr_i,
		.mgmt_wdata_i, .mgmt_wr_i, .mgmt_rd_i, .mgmt_rdata_o, .mgmt_rvalid_o,
		.signal_detect_i, .link_pulse_i, .valid_packet_i, .an_complete_i, .speed100_i,
		.full_duplex_i, .tx_activity_i, .rx_activity_i, .collision_i, .an_enable_o,
		.tx_quiet_o, .flp_enable_o, .an_timeout_o, .forced_speed100_o,
		.forced_full_duplex_o, .advertise_o, .mdi_swap_o, .link_good_o, .isolate_o,
		.mii_oe_o, .tx_accept_o, .media_data_en_o, .media_idle_en_o, .phy_address_o,
		.link_indicator_o, .rate_indicator_o, .activity_collision_indicator_o);
	link_partner_model #(.ADDR(5'h05)) lp (.clk_i, .sel_zero_i(zero_addr),
		.addr_strap_o(management_address_strap_i), .link_pulse_o(link_pulse_i));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic conclude;
		$display("checks %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic idle(input int c);
		repeat (c) @(negedge clk_i);
	endtask : idle
	task automatic waitv(ref logic s, input logic v, input int lim);
		n = 0;
		while (s !== v) begin
			@(negedge clk_i);
			n++;
			if (n > lim) begin
				bad_count++;
				$display("wrong value at %0t: wait ran out", $time);
				conclude();
			end
		end
	endtask : waitv
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk_i);
		mgmt_addr_i = a;
		mgmt_wdata_i = d;
		mgmt_wr_i = 1'b1;
		@(negedge clk_i);
		mgmt_wr_i = 1'b0;
		idle(3);
	endtask : wr
	task automatic rdr(input logic [4:0] a);
		@(negedge clk_i);
		mgmt_addr_i = a;
		mgmt_rd_i = 1'b1;
		@(negedge clk_i);
		mgmt_rd_i = 1'b0;
		waitv(mgmt_rvalid_o, 1'b1, 3);
		rd = mgmt_rdata_o;
	endtask : rdr
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_b_i, zero_addr, mgmt_wr_i, mgmt_rd_i, signal_detect_i, valid_packet_i} = 6'h00;
		{an_complete_i, speed100_i, full_duplex_i, tx_activity_i, rx_activity_i} = 5'h00;
		{collision_i, negotiation_mode_strap_high_i} = 2'h0;
		{ce_i, negotiation_enable_strap_i, negotiation_mode_strap_low_i} = 3'h7;
		{led_scheme_select_strap_i, automatic_crossover_strap_i} = 2'h3;
		mgmt_addr_i = 5'h00;
		mgmt_wdata_i = 16'h0000;
		idle(8);
		rst_b_i = 1'b1;
		idle(10);
		rdr(`REG_PHYCTL);
		check(rd & 16'hC03F, 16'h8025);
		check(phy_address_o, 5'h05);
		check(advertise_o, 4'hC);
		rdr(`REG_ADV);
		check(rd & 16'h01FF, 16'h0181);
		wr(`REG_PHYCTL, 16'h8020);
		check(isolate_o, 1'b0);
		wr(`REG_PHYCTL, 16'h8025);
		$display("straps done");
		wr(`REG_BASIC, 16'h1400);
		check({isolate_o, mii_oe_o, tx_accept_o}, 3'h4);
		check({media_data_en_o, media_idle_en_o}, 2'h1);
		rdr(`REG_BASIC);
		check(rd & 16'h1400, 16'h1400);
		wr(`REG_BASIC, 16'h1000);
		check({isolate_o, mii_oe_o}, 2'h1);
		$display("isolate done");
		wr(`REG_BASIC, 16'h0000);
		wr(`REG_BASIC, 16'h1000);
		check({tx_quiet_o, flp_enable_o}, 2'h2);
		waitv(tx_quiet_o, 1'b0, 25);
		check(n >= 13 && n <= 19, 1'b1);
		idle(1);
		check(flp_enable_o, 1'b1);
		waitv(an_timeout_o, 1'b1, 50);
		check(n >= 35, 1'b1);
		wr(`REG_BASIC, 16'h1200);
		check(tx_quiet_o, 1'b1);
		ce_i = 1'b0;
		idle(30);
		check(tx_quiet_o, 1'b1);
		ce_i = 1'b1;
		waitv(tx_quiet_o, 1'b0, 25);
		$display("negotiation done");
		lp.pulses(6);
		check(link_good_o, 1'b0);
		lp.pulses(1);
		idle(3);
		check(link_good_o, 1'b1);
		check({link_indicator_o, rate_indicator_o}, 2'h0);
		{tx_activity_i, rx_activity_i} = 2'h3;
		idle(1);
		{tx_activity_i, rx_activity_i} = 2'h0;
		idle(3);
		check(activity_collision_indicator_o, 1'b0);
		{speed100_i, signal_detect_i, an_complete_i} = 3'h7;
		idle(4);
		check({rate_indicator_o, link_good_o}, 2'h3);
		{signal_detect_i, an_complete_i} = 2'h0;
		idle(4);
		check({link_good_o, flp_enable_o, tx_quiet_o}, 3'h2);
		$display("link done");
		wr(`REG_LEDOVR, 16'h003A);
		check({activity_collision_indicator_o, rate_indicator_o, link_indicator_o}, 3'h7);
		rdr(`REG_LEDOVR);
		check(rd, 16'h003A);
		rdr(5'h1F);
		check(rd, 16'h0000);
		wr(`REG_LEDOVR, 16'h0000);
		{speed100_i, full_duplex_i} = 2'h1;
		wr(`REG_PHYCTL, 16'h8045);
		check(activity_collision_indicator_o, 1'b0);
		full_duplex_i = 1'b0;
		collision_i = 1'b1;
		wr(`REG_PHYCTL, 16'h8005);
		check(activity_collision_indicator_o, 1'b0);
		collision_i = 1'b0;
		idle(3);
		check(activity_collision_indicator_o, 1'b1);
		wr(`REG_PHYCTL, 16'h4005);
		check(mdi_swap_o, 1'b1);
		wr(`REG_PHYCTL, 16'h0005);
		check(mdi_swap_o, 1'b0);
		check(link_good_o, 1'b0);
		valid_packet_i = 1'b1;
		idle(1);
		valid_packet_i = 1'b0;
		idle(2);
		check(link_good_o, 1'b1);
		$display("led and crossover done");
		zero_addr = 1'b1;
		{negotiation_enable_strap_i, negotiation_mode_strap_high_i} = 2'h1;
		{negotiation_mode_strap_low_i, led_scheme_select_strap_i} = 2'h0;
		automatic_crossover_strap_i = 1'b0;
		rst_b_i = 1'b0;
		idle(8);
		check(phy_address_o, 5'h01);
		rst_b_i = 1'b1;
		idle(10);
		check({isolate_o, phy_address_o}, 6'h20);
		check({an_enable_o, forced_speed100_o, forced_full_duplex_o}, 3'h2);
		check({activity_collision_indicator_o, rate_indicator_o, link_indicator_o}, 3'h2);
		rdr(`REG_PHYCTL);
		check(rd & 16'hC07F, 16'h0000);
		wr(`REG_BASIC, 16'h1000);
		check(an_enable_o, 1'b0);
		wr(`REG_BASIC, 16'h0000);
		wr(`REG_BASIC, 16'h1000);
		check(an_enable_o, 1'b1);
		$display("second reset done");
		conclude();
	end
endmodule : tb
